// ---- common/smbcp_regs.svh ----
// Purpose: constants of the smbus config port and eeprom loader
// Assumes: core clock of 250 MHz
// Notes:   offsets, field positions, reset values and timing counts
`ifndef SMBCP_REGS_SVH
`define SMBCP_REGS_SVH
`define SMBCP_EE_DEV        8'hA0
`define SMBCP_SLV_BASE      8'hB0
`define SMBCP_CRC_FIXED     8'hA5
`define SMBCP_CRC_POLY      8'h07
`define SMBCP_HDR_BYTES     6'h03
`define SMBCP_MAP_BYTES     6'h02
`define SMBCP_CFG_BYTES     6'h25
`define SMBCP_HDR_CRC_BIT   6
`define SMBCP_HDR_MAP_BIT   5
`define SMBCP_HDR_BIG_BIT   3
`define SMBCP_REG_OBS       8'h00
`define SMBCP_OBS_RST_BIT   0
`define SMBCP_OBS_BLK_BIT   1
`define SMBCP_REG_DEFAULT   8'h00
`define SMBCP_CLK_MHZ       250
`define SMBCP_SCL_QTR_NS    625
`define SMBCP_SCL_QTR_CYC   ((`SMBCP_SCL_QTR_NS * `SMBCP_CLK_MHZ) / 1000)
`define SMBCP_TBUF_NS       4700
`define SMBCP_TBUF_CYC      ((`SMBCP_TBUF_NS * `SMBCP_CLK_MHZ + 999) / 1000)
`define SMBCP_THIGH_MAX_NS  50000
`endif

// ---- common/smbcp_pkg.sv ----
// Purpose: types of the smbus config port and eeprom loader
// Assumes: nothing beyond the constants header
// Notes:   one-hot state codes written out
`default_nettype none
package smbcp_pkg;
   typedef struct packed {
      logic       valid;
      logic [7:0] addr;
      logic [7:0] data;
   } smbcp_cfgwr_t;
   typedef struct packed {
      logic master_mode;
      logic loading;
      logic load_done;
      logic crc_err;
      logic bus_idle;
   } smbcp_stat_t;
   typedef struct packed {
      logic sel_lo;
      logic sel_hi;
      logic fanout;
   } smbcp_mux_t;
   typedef enum logic [3:0] {EOP_START = 4'h1, EOP_STOP = 4'h2,
                             EOP_WR = 4'h4, EOP_RD = 4'h8} smbcp_eop_t;
   typedef enum logic [4:0] {MP_IDLE = 5'h01, MP_HDR = 5'h02, MP_MAP = 5'h04,
                             MP_DATA = 5'h08, MP_DONE = 5'h10} smbcp_mp_t;
   typedef enum logic [4:0] {SL_IDLE = 5'h01, SL_RX = 5'h02, SL_ACK = 5'h04,
                             SL_TX = 5'h08, SL_RACK = 5'h10} smbcp_sl_t;
endpackage : smbcp_pkg
`default_nettype wire

// ---- rtl/smbcp_port.sv ----
// Purpose: smbus slave config port with eeprom loader master mode
// Assumes: pins pass two flops; scl/sda level model with pull-ups
// Notes:   registers 1..37 hold the config block, 0 is observation
`include "smbcp_regs.svh"
`default_nettype none
// What this block does
// - strap low/floating at reset selects master mode, eeprom load
// - eeprom addressed with device byte A0, up to 1024 bytes
// - slave address byte is B0 plus twice the select pins
// - select pins pulled low, floating pins give address B0
// - seven-bit address then direction bit, 0 write, 1 read
// - load starts only with permit low; done output follows load
// - first three eeprom bytes form the common header
// - header flag enables crc; otherwise crc byte holds A5
// - map flag takes start from map, else from address and size
// - large-eeprom flag selects block bits in device byte
// - load reads a 37-byte block per device
// - mux select and fanout come only from strap pins
// - strap high enables slave mode and register access
// - sda falling with scl high is start
// - sda rising with scl high is stop
// - bus idle after free time past stop or max clock-high
// - sda stays stable while scl high except start/stop
// - write: start, addr+w, reg addr, data, each acked, stop
// - read: pointer write, restart, addr+r, ack, data, nack, stop
// - device acks address and register bytes by pulling sda low
// - load-done status flag readable once load completes
// - reset bit restores register defaults and self-clears
module smbcp_port
   import smbcp_pkg::*;
#(
   parameter int unsigned SCL_QTR_CYC = `SMBCP_SCL_QTR_CYC,
   parameter int unsigned THIGH_MAX_CYC =
      (`SMBCP_THIGH_MAX_NS * `SMBCP_CLK_MHZ) / 1000
) (
   input  wire logic         core_clk,         // core clock
   input  wire logic         reset_n,          // async reset, low
   input  wire logic         smbus_mode_strap, // 1 slave, 0/float master
   input  wire logic [3:0]   addr_sel,         // slave address pins
   input  wire logic         load_permit_n,    // load permit, low
   input  wire logic         mux_select_lo,    // mux strap
   input  wire logic         mux_select_hi,    // mux strap
   input  wire logic         fanout_strap,     // fanout strap
   input  wire logic         scl_in,           // scl wire level
   input  wire logic         sda_in,           // sda wire level
   output logic              scl_out,          // scl drive value
   output logic              scl_oe_n,         // scl drive enable, low
   output logic              sda_out,          // sda drive value
   output logic              sda_oe_n,         // sda drive enable, low
   output logic              load_done_n,      // load done, low
   output smbcp_stat_t       status,           // status flags
   output smbcp_mux_t        mux_ctrl,         // mux/fanout controls
   output smbcp_cfgwr_t      cfg_wr            // register write event
);
   localparam int unsigned QTR = SCL_QTR_CYC;
   localparam int unsigned TBUF = `SMBCP_TBUF_CYC;
   logic [10:0] pin_a, pin_b;
   logic        scl_s, sda_s, scl_d, sda_d, permit_n_s;
   logic [3:0]  ad;
   logic        scl_r, scl_f, start_c, stop_c;
   logic [1:0]  strap_cnt;
   logic        strap_taken, mode_slave, bus_idle, after_stop;
   logic [15:0] hi_cnt;
   smbcp_eop_t  eng_op;
   logic        eng_go, eng_busy, eng_nack, eng_idle;
   logic [7:0]  eng_tx, eng_sh, eng_rx, eng_q;
   logic [1:0]  eng_ph;
   logic [3:0]  eng_bc;
   logic        m_scl_rel, m_sda_rel;
   smbcp_mp_t   mphase;
   logic [2:0]  mstep;
   logic [5:0]  left;
   logic [9:0]  ea;
   logic        rd_pend, done, crc_err, big;
   logic [23:0] hdr;
   logic [15:0] map;
   logic [7:0]  crc_acc, dev_w;
   logic        lw_valid, sw_valid, loading, slave_en;
   logic [7:0]  lw_idx, lw_data, sw_idx, sw_data, rdval, my_addr;
   smbcp_sl_t   sl_state;
   logic [3:0]  sl_cnt;
   logic [7:0]  sl_sh, sl_ptr;
   logic [1:0]  sl_byte;
   logic        sl_rw, sl_acked, s_sda_rel, blk;
   logic [7:0]  cfg [1:37];

   function automatic logic [7:0] crc8(input logic [7:0] c,
                                       input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ({r[6:0], 1'b0} ^ `SMBCP_CRC_POLY) : {r[6:0], 1'b0};
      end
      return r;
   endfunction : crc8

   // two-flop sync of every pin; third scl/sda stage for edges
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_a <= 11'h7FF;
         pin_b <= 11'h7FF;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         pin_a <= {scl_in, sda_in, load_permit_n, smbus_mode_strap,
                   addr_sel, mux_select_lo, mux_select_hi, fanout_strap};
         pin_b <= pin_a;
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end
   assign scl_s = pin_b[10];
   assign sda_s = pin_b[9];
   assign permit_n_s = pin_b[8];
   assign ad = pin_b[6:3];
   assign scl_r = scl_s & ~scl_d;
   assign scl_f = ~scl_s & scl_d;
   assign start_c = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
   assign my_addr = 8'(`SMBCP_SLV_BASE + {3'h0, ad, 1'b0});
   assign loading = (mphase != MP_IDLE) && (mphase != MP_DONE);
   assign slave_en = strap_taken && (mode_slave || mphase == MP_DONE);
   assign eng_idle = ~eng_busy & ~eng_go;
   assign big = hdr[16 + `SMBCP_HDR_BIG_BIT];

   // strap caught once the synchroniser has settled after reset
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         strap_cnt   <= 2'h0;
         strap_taken <= 1'b0;
         mode_slave  <= 1'b0;
      end else if (!strap_taken) begin
         strap_cnt <= 2'(strap_cnt + 2'h1);
         if (strap_cnt == 2'h3) begin
            strap_taken <= 1'b1;
            mode_slave  <= pin_b[7];
         end
      end
   end

   // idle after tbuf past stop, or max clock-high
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         hi_cnt     <= 16'h0;
         bus_idle   <= 1'b0;
         after_stop <= 1'b0;
      end else begin
         if (stop_c) after_stop <= 1'b1;
         else if (start_c) after_stop <= 1'b0;
         if (!(scl_s && sda_s)) begin
            hi_cnt   <= 16'h0;
            bus_idle <= 1'b0;
         end else if (!bus_idle) begin
            hi_cnt <= 16'(hi_cnt + 16'h1);
            if ((after_stop && hi_cnt >= 16'(TBUF)) ||
                hi_cnt >= 16'(THIGH_MAX_CYC)) bus_idle <= 1'b1;
         end
      end
   end

   // bit engine: four quarter phases per scl period, no stretching
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         eng_busy  <= 1'b0;
         eng_ph    <= 2'h0;
         eng_bc    <= 4'h0;
         eng_q     <= 8'h0;
         eng_sh    <= 8'h0;
         eng_rx    <= 8'h0;
         m_scl_rel <= 1'b1;
         m_sda_rel <= 1'b1;
      end else if (eng_go) begin
         eng_busy <= 1'b1;
         eng_ph   <= 2'h0;
         eng_bc   <= 4'h0;
         eng_q    <= 8'h0;
         eng_sh   <= eng_tx;
      end else if (eng_busy && eng_q != 8'(QTR - 1)) begin
         eng_q <= 8'(eng_q + 8'h1);
      end else if (eng_busy) begin
         eng_q  <= 8'h0;
         eng_ph <= 2'(eng_ph + 2'h1);
         case (eng_op)
            EOP_START: begin
               if (eng_ph == 2'h0) m_sda_rel <= 1'b1;
               if (eng_ph == 2'h0) m_scl_rel <= 1'b1;
               if (eng_ph == 2'h1) m_sda_rel <= 1'b0;
               if (eng_ph == 2'h2) m_scl_rel <= 1'b0;
               if (eng_ph == 2'h2) eng_busy <= 1'b0;
            end
            EOP_STOP: begin
               if (eng_ph == 2'h0) m_sda_rel <= 1'b0;
               if (eng_ph == 2'h1) m_scl_rel <= 1'b1;
               if (eng_ph == 2'h2) m_sda_rel <= 1'b1;
               if (eng_ph == 2'h2) eng_busy <= 1'b0;
            end
            default: begin
               // sda changes only while scl low
               if (eng_ph == 2'h0)
                  m_sda_rel <= (eng_bc == 4'h8) ?
                     (eng_op == EOP_RD ? eng_nack : 1'b1) :
                     (eng_op == EOP_WR ? eng_sh[7] : 1'b1);
               if (eng_ph == 2'h1) m_scl_rel <= 1'b1;
               if (eng_ph == 2'h2 && eng_bc != 4'h8)
                  eng_rx <= {eng_rx[6:0], sda_s};
               if (eng_ph == 2'h3) begin
                  m_scl_rel <= 1'b0;
                  eng_sh    <= {eng_sh[6:0], 1'b0};
                  eng_bc    <= 4'(eng_bc + 4'h1);
                  if (eng_bc == 4'h8) eng_busy <= 1'b0;
               end
            end
         endcase
      end
   end

   // block bits of the address ride in the device byte
   assign dev_w = `SMBCP_EE_DEV | {5'h0, big ? ea[9:8] : 2'h0, 1'b0};

   // loader sequencer: random-address read of left bytes at ea
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mphase <= MP_IDLE;
         mstep <= 3'h0;
         left <= 6'h0;
         ea <= 10'h0;
         rd_pend <= 1'b0;
         done <= 1'b0;
         crc_err <= 1'b0;
         hdr <= 24'h0;
         map <= 16'h0;
         crc_acc <= 8'h0;
         eng_go <= 1'b0;
         eng_op <= EOP_START;
         eng_tx <= 8'h0;
         eng_nack <= 1'b1;
         lw_valid <= 1'b0;
         lw_idx <= 8'h0;
         lw_data <= 8'h0;
      end else begin
         eng_go   <= 1'b0;
         lw_valid <= 1'b0;
         case (mphase)
            MP_IDLE: begin
               if (strap_taken && !mode_slave && !permit_n_s) begin
                  mphase <= MP_HDR;
                  mstep  <= 3'h0;
                  ea     <= 10'h0;
                  left   <= `SMBCP_HDR_BYTES;
               end
            end
            MP_HDR, MP_MAP, MP_DATA: begin
               if (eng_idle) begin
                  case (mstep)
                     3'h0, 3'h3, 3'h6: begin
                        eng_go <= 1'b1;
                        eng_op <= (mstep == 3'h6) ? EOP_STOP : EOP_START;
                        mstep  <= 3'(mstep + 3'h1);
                     end
                     3'h1, 3'h2, 3'h4: begin
                        eng_go <= 1'b1;
                        eng_op <= EOP_WR;
                        eng_tx <= (mstep == 3'h1) ? dev_w :
                                  (mstep == 3'h2) ? ea[7:0] : (dev_w | 8'h01);
                        mstep  <= 3'(mstep + 3'h1);
                     end
                     3'h5: begin
                        if (rd_pend) begin
                           rd_pend <= 1'b0;
                           left    <= 6'(left - 6'h1);
                           if (left == 6'h1) mstep <= 3'h6;
                           if (mphase == MP_HDR) hdr <= {hdr[15:0], eng_rx};
                           if (mphase == MP_MAP) map <= {map[7:0], eng_rx};
                           if (mphase == MP_DATA) begin
                              lw_valid <= 1'b1;
                              lw_idx   <= 8'(`SMBCP_CFG_BYTES - left + 6'h1);
                              lw_data  <= eng_rx;
                              crc_acc  <= crc8(crc_acc, eng_rx);
                           end
                        end else begin
                           eng_go   <= 1'b1;
                           eng_op   <= EOP_RD;
                           eng_nack <= (left == 6'h1);
                           rd_pend  <= 1'b1;
                        end
                     end
                     default: begin
                        mstep <= 3'h0;
                        left  <= `SMBCP_CFG_BYTES;
                        if (mphase == MP_HDR &&
                            hdr[16 + `SMBCP_HDR_MAP_BIT]) begin
                           mphase <= MP_MAP;
                           left   <= `SMBCP_MAP_BYTES;
                           ea     <= 10'(10'd3 + {5'h0, ad, 1'b0});
                        end else if (mphase == MP_HDR) begin
                           mphase <= MP_DATA;
                           ea     <= 10'(10'd3 + 10'(ad) * 10'd37);
                        end else if (mphase == MP_MAP) begin
                           mphase <= MP_DATA;
                           ea     <= map[9:0];
                        end else begin
                           mphase <= MP_DONE;
                           done   <= 1'b1;
                           crc_err <= hdr[16 + `SMBCP_HDR_CRC_BIT] ?
                              (crc_acc != hdr[15:8]) :
                              (hdr[15:8] != `SMBCP_CRC_FIXED);
                        end
                     end
                  endcase
               end
            end
            MP_DONE: mphase <= MP_DONE;
            default: mphase <= MP_IDLE;
         endcase
      end
   end

   // slave byte machine; stop, idle or disable end any message
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sl_state <= SL_IDLE;
         sl_cnt <= 4'h0;
         sl_sh <= 8'h0;
         sl_ptr <= 8'h0;
         sl_byte <= 2'h0;
         sl_rw <= 1'b0;
         sl_acked <= 1'b0;
         s_sda_rel <= 1'b1;
         sw_valid <= 1'b0;
         sw_idx <= 8'h0;
         sw_data <= 8'h0;
      end else begin
         sw_valid <= 1'b0;
         if (!slave_en || stop_c || (bus_idle && !start_c)) begin
            sl_state  <= SL_IDLE;
            s_sda_rel <= 1'b1;
         end else if (start_c) begin
            sl_state  <= SL_RX;
            sl_cnt    <= 4'h0;
            sl_byte   <= 2'h0;
            s_sda_rel <= 1'b1;
         end else begin
            case (sl_state)
               SL_RX: begin
                  if (scl_r) begin
                     sl_sh  <= {sl_sh[6:0], sda_s};
                     sl_cnt <= 4'(sl_cnt + 4'h1);
                  end else if (scl_f && sl_cnt == 4'h8) begin
                     if (sl_byte == 2'h0 && sl_sh[7:1] != my_addr[7:1]) begin
                        sl_state <= SL_IDLE;
                     end else begin
                        s_sda_rel <= 1'b0;
                        sl_state  <= SL_ACK;
                        if (sl_byte == 2'h0) sl_rw <= sl_sh[0];
                        else if (sl_byte == 2'h1) sl_ptr <= sl_sh;
                        else begin
                           sw_valid <= 1'b1;
                           sw_idx   <= sl_ptr;
                           sw_data  <= sl_sh;
                           sl_ptr   <= 8'(sl_ptr + 8'h1);
                        end
                     end
                  end
               end
               SL_ACK: begin
                  if (scl_f) begin
                     sl_cnt <= 4'h0;
                     if (sl_rw && sl_byte == 2'h0) begin
                        sl_state  <= SL_TX;
                        sl_sh     <= rdval;
                        s_sda_rel <= rdval[7];
                     end else begin
                        sl_state  <= SL_RX;
                        s_sda_rel <= 1'b1;
                        if (sl_byte != 2'h2) sl_byte <= 2'(sl_byte + 2'h1);
                     end
                  end
               end
               SL_TX: begin
                  if (scl_f && sl_cnt == 4'h7) begin
                     s_sda_rel <= 1'b1;
                     sl_state  <= SL_RACK;
                  end else if (scl_f) begin
                     s_sda_rel <= sl_sh[6];
                     sl_sh     <= {sl_sh[6:0], 1'b0};
                     sl_cnt    <= 4'(sl_cnt + 4'h1);
                  end
               end
               SL_RACK: begin
                  if (scl_r) begin
                     sl_acked <= ~sda_s;
                     if (!sda_s) sl_ptr <= 8'(sl_ptr + 8'h1);
                  end else if (scl_f && sl_acked) begin
                     sl_state  <= SL_TX;
                     sl_cnt    <= 4'h0;
                     sl_sh     <= rdval;
                     s_sda_rel <= rdval[7];
                  end else if (scl_f) begin
                     sl_state <= SL_IDLE;
                  end
               end
               default: sl_state <= SL_IDLE;
            endcase
         end
      end
   end

   // register file; bit 1 of register 0 guards the reset bit
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         blk <= 1'b0;
         for (int i = 1; i <= 37; i++) cfg[i] <= `SMBCP_REG_DEFAULT;
      end else if (sw_valid && sw_idx == `SMBCP_REG_OBS) begin
         if (sw_data[`SMBCP_OBS_RST_BIT] && !blk) begin
            // defaults back, reset bit never stored
            blk <= 1'b0;
            for (int i = 1; i <= 37; i++) cfg[i] <= `SMBCP_REG_DEFAULT;
         end else begin
            blk <= sw_data[`SMBCP_OBS_BLK_BIT];
         end
      end else if (sw_valid && sw_idx >= 8'h01 && sw_idx <= 8'h25) begin
         cfg[sw_idx] <= sw_data;
      end else if (lw_valid) begin
         cfg[lw_idx] <= lw_data;
      end
   end

   // read mux; unmapped pointers read zero
   always_comb begin
      rdval = 8'h00;
      if (sl_ptr == `SMBCP_REG_OBS) rdval = {1'b0, ad, done, blk, 1'b0};
      else if (sl_ptr >= 8'h01 && sl_ptr <= 8'h25) rdval = cfg[sl_ptr];
   end

   // registered outputs; master owns the pins only while loading
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
         load_done_n <= 1'b1;
         status <= '0;
         mux_ctrl <= '0;
         cfg_wr <= '0;
      end else begin
         scl_oe_n <= loading ? m_scl_rel : 1'b1;
         sda_oe_n <= loading ? m_sda_rel : s_sda_rel;
         load_done_n <= ~done;
         status <= '{master_mode: strap_taken & ~mode_slave,
                     loading: loading, load_done: done,
                     crc_err: crc_err, bus_idle: bus_idle};
         mux_ctrl <= '{sel_lo: pin_b[2], sel_hi: pin_b[1], fanout: pin_b[0]};
         cfg_wr <= '{valid: sw_valid | lw_valid,
                     addr: sw_valid ? sw_idx : lw_idx,
                     data: sw_valid ? sw_data : lw_data};
      end
   end
endmodule : smbcp_port
`default_nettype wire

// ---- dv/smbcp_monitor.sv ----
// Purpose: port checker on the smbus config port
// Assumes: top ports only
// Notes:   bind at the foot
`default_nettype none
module smbcp_monitor
   import smbcp_pkg::*;
(
   input wire logic         core_clk,      // core clock
   input wire logic         reset_n,       // async reset
   input wire logic         load_permit_n, // permit pin
   input wire logic         scl_out,       // scl value
   input wire logic         sda_out,       // sda value
   input wire logic         scl_oe_n,      // scl enable
   input wire logic         load_done_n,   // done pin
   input wire smbcp_stat_t  status,        // flags
   input wire smbcp_cfgwr_t cfg_wr         // write event
);
   logic [5:0] n_wr;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // writes since reset, saturating so a long run cannot wrap
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) n_wr <= 6'h00;
      else if (cfg_wr.valid && n_wr != 6'h3F) n_wr <= n_wr + 6'h01;
   end
   low_only_a: assert property (!scl_out && !sda_out)
      else $error("pin driven high");
   done_holds_a: assert property (!load_done_n |=> !load_done_n)
      else $error("done released");
   done_permit_a: assert property
      (load_permit_n && load_done_n |=> load_done_n)
      else $error("done without permit");
   done_count_a: assert property ($fell(load_done_n) |-> n_wr >= 6'h25)
      else $error("done too early");
   wr_pulse_a: assert property (cfg_wr.valid |=> !cfg_wr.valid)
      else $error("write pulse long");
   wr_range_a: assert property (cfg_wr.valid |-> cfg_wr.addr <= 8'h25)
      else $error("write out of block");
   slave_scl_a: assert property (!status.master_mode |-> scl_oe_n)
      else $error("slave drives scl");
   released_a: assert property (!load_done_n |-> scl_oe_n)
      else $error("scl held after load");
   cover property ($fell(load_done_n));
   cover property (cfg_wr.valid && !status.master_mode);
   cover property ($rose(status.bus_idle));
endmodule : smbcp_monitor
bind smbcp_port smbcp_monitor smbcp_monitor_i (.*);
`default_nettype wire

// ---- dv/smbcp_ee_model.sv ----
// Purpose: serial eeprom on the shared bus
// Assumes: pull-ups on both wires
// Notes:   reads only, 256-byte part
`default_nettype none
module smbcp_ee_model (
   input wire logic       scl,      // wire level
   input wire logic       sda,      // wire level
   input wire logic [7:0] hdr,      // header flag byte
   output logic           sda_oe_n  // low pulls sda
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] sh, tx, ptr;
   logic       rd = 1'b0, on = 1'b0;
   int         bc = 0, nb = 0;
   initial sda_oe_n = 1'b1;
   // start opens a frame, stop closes it
   always @(sda) if (scl) begin
      on = !sda; bc = 0; nb = 0; rd = 1'b0; sda_oe_n = 1'b1;
   end
   // bits taken with scl high; a host nack ends the read
   always @(posedge scl) if (on) begin
      if (bc < 8) sh = {sh[6:0], sda};
      else if (rd && nb > 0 && sda) on = 1'b0;
      bc++;
   end
   // ack only A0/A1, then pointer; crc byte holds the fixed A5
   always @(negedge scl) if (on) begin
      #4; // short hold, host scl low lasts only 16 to 28 ns
      if (bc == 8 && !(rd && nb > 0)) begin
         if (nb == 0) rd = sh[0];
         if (nb == 0) on = sh[7:1] == 7'h50;
         if (nb == 1) ptr = sh;
         nb++;
         sda_oe_n = !on;
      end else if (bc == 9) begin
         bc = 0;
         tx = ptr == 8'h00 ? hdr : ptr == 8'h01 ? 8'hA5 : ptr ^ 8'h5A;
         ptr = ptr + 8'(rd);
         sda_oe_n = !rd | tx[7];
      end else if (rd && nb > 0) sda_oe_n = bc == 8 | tx[7 - bc];
   end
endmodule : smbcp_ee_model
`default_nettype wire

// ---- dv/smbcp_port_tb.sv ----
// Purpose: bench of the port, loader then slave
// Assumes: wired-and bus with pull-ups
// Notes:   loader runs on a fast scl so the run stays short
`default_nettype none
module smbcp_port_tb;
   import smbcp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0, reset_n = 1'b0, strap = 1'b0, permit_n = 1'b1;
   logic h_scl = 1'b1, h_sda = 1'b1, scl_oe_n, sda_oe_n, scl_out, sda_out;
   logic ee_oe_n, load_done_n, a;
   logic [2:0] mx = 3'h5, acks;
   logic [3:0] addr_sel = 4'h0;
   logic [7:0] q, hdr = 8'h00;
   smbcp_stat_t status;
   smbcp_mux_t mux_ctrl;
   smbcp_cfgwr_t cfg_wr, last_wr;
   int n_errors = 0, n_tests = 0, k;
   wire scl_w = h_scl & (scl_oe_n | scl_out);
   wire sda_w = h_sda & ee_oe_n & (sda_oe_n | sda_out);
   // clock, and the latest write kept for later compare
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) if (cfg_wr.valid) last_wr <= cfg_wr;
   smbcp_port #(.SCL_QTR_CYC(2), .THIGH_MAX_CYC(200)) smbcp_port_i (
      .core_clk, .reset_n,
      .smbus_mode_strap(strap), .addr_sel, .load_permit_n(permit_n),
      .mux_select_lo(mx[2]), .mux_select_hi(mx[1]), .fanout_strap(mx[0]),
      .scl_in(scl_w), .sda_in(sda_w), .scl_out, .scl_oe_n, .sda_out,
      .sda_oe_n, .load_done_n, .status, .mux_ctrl, .cfg_wr);
   smbcp_ee_model smbcp_ee_model_i (.scl(scl_w), .sda(sda_w),
      .sda_oe_n(ee_oe_n), .hdr);
   task clk(input int n); repeat (n) @(negedge core_clk); endtask : clk
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task wrap_up;
      $display("tests=%0d errors=%0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   task rst(input logic s, input logic [3:0] ad, input logic [2:0] m);
      reset_n = 1'b0; strap = s; addr_sel = ad; mx = m; permit_n = 1'b1;
      clk(16); reset_n = 1'b1; clk(1500);
   endtask : rst
   // host bit: scl low 6 clocks, high 2, so the 32 ns period holds
   task hb(input logic b, output logic r);
      clk(5); h_sda = b; clk(1); h_scl = 1'b1; clk(1); r = sda_w; clk(1);
      h_scl = 1'b0;
   endtask : hb
   task xb(input logic [7:0] d);
      for (int i = 7; i >= 0; i--) hb(d[i], q[i]);
      hb(1'b1, a); acks = {acks[1:0], a};
   endtask : xb
   // waits out the slave's ack hold before moving sda
   task go; clk(5); h_sda = 1'b1; clk(1); h_scl = 1'b1; clk(4);
      h_sda = 1'b0; clk(4); h_scl = 1'b0; endtask : go
   task stop; clk(5); h_sda = 1'b0; clk(1); h_scl = 1'b1; clk(4);
      h_sda = 1'b1; clk(1300); endtask : stop
   task t_load(input logic [7:0] h, input logic [7:0] b);
      hdr = h;
      rst(1'b0, 4'h1, 3'h5);
      chk(8'(load_done_n), 8'h01);
      // first device of the chain has its permit tied low
      permit_n = 1'b0; k = 0;
      for (int i = 0; i < 20000 && load_done_n === 1'b1; i++) begin
         clk(1);
         if (cfg_wr.valid === 1'b1) begin
            chk(cfg_wr.addr, 8'(k + 1));
            chk(cfg_wr.data, (b + 8'(k)) ^ 8'h5A);
            k++;
         end
      end
      if (load_done_n !== 1'b0) n_errors++;
      chk(8'(k), 8'h25);
      chk(8'(status.load_done), 8'h01);
      chk(8'(status.crc_err), 8'h00);
      chk(8'(mux_ctrl), 8'h05);
      clk(8); chk(8'(scl_oe_n & sda_oe_n), 8'h01);
   endtask : t_load
   task t_slave;
      rst(1'b1, 4'h3, 3'h2);
      go; xb(8'hB6); xb(8'h05); xb(8'h3C); stop;
      chk(8'(acks), 8'h00);
      chk(last_wr.data, 8'h3C);
      chk(last_wr.addr, 8'h05);
      go; xb(8'hB6); xb(8'h05); go; xb(8'hB7); xb(8'hFF); stop;
      chk(q, 8'h3C);
      chk(8'(acks), 8'h01);
      go; xb(8'hB6); xb(8'h00); go; xb(8'hB7); xb(8'hFF); stop;
      chk(q, 8'h18);
      // reset bit brings register 5 back to default
      go; xb(8'hB6); xb(8'h00); xb(8'h01); stop;
      go; xb(8'hB6); xb(8'h05); go; xb(8'hB7); xb(8'hFF); stop;
      chk(q, 8'h00);
      go; xb(8'hB0); stop;
      chk(8'(a), 8'h01);
      chk(8'(mux_ctrl), 8'h02);
   endtask : t_slave
   initial begin
      t_load(8'h00, 8'h28);
      t_load(8'h20, 8'h5C);
      t_slave;
      wrap_up;
   end
endmodule : smbcp_port_tb
`default_nettype wire
